// File: hdl/addr_map_pkg.sv
/*
 * Shared constants and carrier types for the address space decoder:
 * segment numbers, memory limits, program counter wrap points, the
 * special function register aliases and the request and answer structs.
 * Assumes a 24-bit byte address made of an 8-bit segment and a 16-bit
 * offset, as seen by the core's fetch and data units.
 */
package addr_map_pkg;

    localparam int ADDR_W = 24;

    // Segments.
    localparam logic [7:0] SEG_CODE = 8'hFF;
    localparam logic [7:0] SEG_LAST_LIN = 8'hFE;
    localparam logic [7:0] SEG_DATA = 8'h00;
    localparam logic [7:0] SEG_DATA_TOP = 8'h01;

    // Program counter value after reset.
    localparam logic [23:0] PC_RESET = 24'hFF0000;

    // On-chip code memory, 32 KB at the bottom of the code segment.
    localparam logic [15:0] CODE_LAST = 16'h7FFF;
    // Top eight bytes whose prefetch can run onto the external bus.
    localparam logic [15:0] CODE_TOP8_FIRST = 16'h7FF8;

    // Register file of 32 bytes followed by 1 KB of data RAM.
    localparam logic [15:0] REGFILE_BYTES = 16'h0020;
    localparam logic [15:0] RAM_LIMIT = 16'h0420;
    localparam logic [15:0] BIT_RAM_FIRST = 16'h0020;
    localparam logic [15:0] BIT_RAM_LAST = 16'h00FF;

    // Upper 16 KB of region 00: mirroring the upper 16 KB of code.
    localparam logic [15:0] MIRROR_FIRST = 16'hC000;
    localparam logic [1:0] MIRROR_CODE_HI = 2'b01;

    // Core special function registers and their register file bytes.
    localparam logic [7:0] SFR_ACC = 8'hE0;
    localparam logic [7:0] SFR_B = 8'hF0;
    localparam logic [7:0] SFR_SP = 8'h81;
    localparam logic [7:0] SFR_SPH = 8'hBE;
    localparam logic [7:0] SFR_DPL = 8'h82;
    localparam logic [7:0] SFR_DPH = 8'h83;
    localparam logic [7:0] SFR_DPXL = 8'h84;
    localparam logic [7:0] RF_ACC = 8'h0B;
    localparam logic [7:0] RF_B = 8'h0A;
    localparam logic [7:0] RF_SP = 8'h3F;
    localparam logic [7:0] RF_SPH = 8'h3E;
    localparam logic [7:0] RF_DPL = 8'h3B;
    localparam logic [7:0] RF_DPH = 8'h3A;
    localparam logic [7:0] RF_DPXL = 8'h39;

    typedef enum logic [1:0] {
        SPACE_CODE,
        SPACE_DATA,
        SPACE_SFR
    } space_t;

    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_CODE,
        TGT_RAM,
        TGT_SFR,
        TGT_EXT
    } target_t;

    typedef struct packed {
        logic valid;
        space_t space;
        logic [23:0] addr;
        logic is_const;
        logic bit_op;
    } access_req_t;

    typedef struct packed {
        target_t target;
        logic [23:0] local_addr;
        logic ext_start;
        logic bit_ok;
        logic sfr_alias;
        logic prefetch_hazard;
    } decode_t;

endpackage

// File: hdl/address_space_decoder.sv
/*
 * Address space decoder and program counter wrap logic.
 * Each access presented on the request port is routed to exactly one of
 * on-chip code, on-chip RAM, the SFR region or the external bus, and the
 * answer is registered one clock later. The program counter is held here
 * and stepped or loaded by the core.
 * Assumes the external access select level arrives from a pin and the
 * code mirror disable bit comes from configuration logic on clk_sys.
 * The pin is used only after two flops, so a change of level reaches
 * the decode two to three cycles later; the core keeps code requests
 * idle across such a change, or a few fetches take the old route.
 */
// How it works
// - Select high: 32 KB code at FF: bottom
// - Select low: every code fetch goes external
// - PC at end of FF: wraps to FF:0000h
// - PC past end of FE: continues FF:0000h
// - PC past end of 01: wraps to 00:
// - Flag execution in the top eight code bytes
// - Constant reads from top bytes stay internal
// - 1 KB RAM sits above 32-byte register file
// - RAM bytes 20h through FFh are bit addressable
// - Code fetches never reach the data RAM
// - Mirror enabled maps upper code into 00:
// - Mirror with select low fetches external FF:
// - Mirror disabled hides code from region 00:
// - Unmapped data accesses go to external bus
// - SFRs decoded in their own S: region
// - Every SFR supports single-bit access
// - Core SFRs alias their register file bytes
`timescale 1ns/1ps

module address_space_decoder
    import addr_map_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic external_access_select,
    input wire logic code_mirror_disable,
    input wire access_req_t req,
    input wire logic pc_load,
    input wire logic [23:0] pc_load_value,
    input wire logic pc_step_en,
    input wire logic [2:0] pc_step,
    output decode_t answer,
    output logic [23:0] pc
);

    // Synchroniser for the access select pin.
    logic ea_meta_reg;
    logic ea_sync_reg;
    logic ea_meta_next;
    logic ea_sync_next;

    // Decode state.
    decode_t answer_reg;
    decode_t answer_next;

    // Program counter state.
    logic [23:0] pc_reg;
    logic [23:0] pc_next;

    // Combinational helpers.
    logic [7:0] seg;
    logic [15:0] off;
    logic [7:0] rf_index;
    logic rf_hit;
    logic [16:0] pc_sum;
    logic [7:0] pc_seg;
    logic code_rom_hit;
    logic ram_hit;
    logic mirror_hit;
    logic top8_hit;
    logic bit_ram_hit;

    assign seg = req.addr[23:16];
    assign off = req.addr[15:0];
    assign pc_seg = pc_reg[23:16];

    // The pin level is only read after the second flop; a board may change
    // it at any time, but fetches in the next few cycles may take the old route.
    always_comb
    begin
        ea_meta_next = external_access_select;
        ea_sync_next = ea_meta_reg;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ea_meta_reg <= 1'b0;
            ea_sync_reg <= 1'b0;
        end
        else
        begin
            ea_meta_reg <= ea_meta_next;
            ea_sync_reg <= ea_sync_next;
        end
    end

    // Region flags of the request, shared by the router below.
    always_comb
    begin
        code_rom_hit = seg == SEG_CODE && off <= CODE_LAST;
        ram_hit = seg == SEG_DATA && off < RAM_LIMIT;
        mirror_hit = seg == SEG_DATA && off >= MIRROR_FIRST;
        top8_hit = off >= CODE_TOP8_FIRST && off <= CODE_LAST;
        bit_ram_hit = off >= BIT_RAM_FIRST && off <= BIT_RAM_LAST;
    end

    // Core SFRs that share storage with the register file.
    // Only the low byte of the address names an SFR in S:.
    always_comb
    begin
        rf_hit = 1'b1;
        rf_index = 8'h00;
        if (req.addr[7:0] == SFR_ACC)
        begin
            rf_index = RF_ACC;
        end
        else if (req.addr[7:0] == SFR_B)
        begin
            rf_index = RF_B;
        end
        else if (req.addr[7:0] == SFR_SP)
        begin
            rf_index = RF_SP;
        end
        else if (req.addr[7:0] == SFR_SPH)
        begin
            rf_index = RF_SPH;
        end
        else if (req.addr[7:0] == SFR_DPL)
        begin
            rf_index = RF_DPL;
        end
        else if (req.addr[7:0] == SFR_DPH)
        begin
            rf_index = RF_DPH;
        end
        else if (req.addr[7:0] == SFR_DPXL)
        begin
            rf_index = RF_DPXL;
        end
        else
        begin
            rf_hit = 1'b0;
        end
    end

    // Route one access.
    always_comb
    begin
        answer_next = '0;
        answer_next.target = TGT_NONE;
        if (req.valid)
        begin
            case (req.space)
                SPACE_CODE:
                begin
                    // The data RAM is never a candidate here.
                    if (ea_sync_reg && code_rom_hit)
                    begin
                        answer_next.target = TGT_CODE;
                        answer_next.local_addr = {8'h00, off};
                        // Instruction fetches near the top may drag the
                        // prefetcher onto the bus; constant reads do not.
                        answer_next.prefetch_hazard =
                            !req.is_const && top8_hit;
                    end
                    else
                    begin
                        answer_next.target = TGT_EXT;
                        answer_next.local_addr = req.addr;
                    end
                end
                SPACE_DATA:
                begin
                    if (ram_hit)
                    begin
                        // Register file bytes then the 1 KB RAM.
                        answer_next.target = TGT_RAM;
                        answer_next.local_addr = {8'h00, off};
                        answer_next.bit_ok =
                            req.bit_op && bit_ram_hit;
                    end
                    else if (mirror_hit && !code_mirror_disable)
                    begin
                        // Window offsets land in the upper half of code.
                        if (ea_sync_reg)
                        begin
                            answer_next.target = TGT_CODE;
                            answer_next.local_addr =
                                {8'h00, MIRROR_CODE_HI, off[13:0]};
                        end
                        else
                        begin
                            answer_next.target = TGT_EXT;
                            answer_next.local_addr =
                                {SEG_CODE, MIRROR_CODE_HI, off[13:0]};
                        end
                    end
                    else
                    begin
                        // Includes the mirror window when it is disabled.
                        answer_next.target = TGT_EXT;
                        answer_next.local_addr = req.addr;
                    end
                end
                SPACE_SFR:
                begin
                    if (rf_hit)
                    begin
                        answer_next.target = TGT_RAM;
                        answer_next.local_addr = {16'h0000, rf_index};
                        answer_next.sfr_alias = 1'b1;
                    end
                    else
                    begin
                        answer_next.target = TGT_SFR;
                        answer_next.local_addr = {16'h0000, req.addr[7:0]};
                    end
                    answer_next.bit_ok = req.bit_op;
                end
                default:
                begin
                    answer_next.target = TGT_NONE;
                end
            endcase
            answer_next.ext_start = answer_next.target == TGT_EXT;
        end
    end

    // Registering the answer puts every output on a flop; the price is
    // one cycle of latency for every access.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            answer_reg <= '0;
        end
        else
        begin
            answer_reg <= answer_next;
        end
    end

    // Program counter. A load wins over a step in the same cycle.
    // Steps are at most seven bytes, so one carry is the only wrap case.
    always_comb
    begin
        pc_sum = {1'b0, pc_reg[15:0]} + {14'h0000, pc_step};
        pc_next = pc_reg;
        if (pc_load)
        begin
            pc_next = pc_load_value;
        end
        else if (pc_step_en)
        begin
            if (!pc_sum[16])
            begin
                pc_next = {pc_seg, pc_sum[15:0]};
            end
            else if (pc_seg == SEG_CODE)
            begin
                pc_next = {SEG_CODE, pc_sum[15:0]};
            end
            else if (pc_seg == SEG_LAST_LIN)
            begin
                pc_next = {SEG_CODE, pc_sum[15:0]};
            end
            else if (pc_seg == SEG_DATA_TOP)
            begin
                // Keeps execution out of the reserved segments above.
                pc_next = {SEG_DATA, pc_sum[15:0]};
            end
            else
            begin
                pc_next = {pc_seg + 8'h01, pc_sum[15:0]};
            end
        end
    end

    // Reset starts execution at the bottom of the code segment.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pc_reg <= PC_RESET;
        end
        else
        begin
            pc_reg <= pc_next;
        end
    end

    assign answer = answer_reg;
    assign pc = pc_reg;

endmodule // address_space_decoder

// File: test/address_space_decoder_checker.sv
/* Assertion checker for the address space decoder's ports.
   Assumes addr_map_pkg and the single clk_sys domain. */
`timescale 1ns/1ps
module address_space_decoder_checker
    import addr_map_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic external_access_select,
    input wire logic code_mirror_disable,
    input wire access_req_t req,
    input wire logic pc_load,
    input wire logic [23:0] pc_load_value,
    input wire logic pc_step_en,
    input wire logic [2:0] pc_step,
    input wire decode_t answer,
    input wire logic [23:0] pc
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic c_req;
    logic d00;
    logic adv;
    assign c_req = req.valid && req.space == SPACE_CODE;
    assign d00 = req.valid && req.space == SPACE_DATA
        && req.addr[23:16] == SEG_DATA;
    // Only a step that carries out of the offset reaches a segment end.
    assign adv = pc_step_en && !pc_load
        && ({1'b0, pc[15:0]} + {14'h0000, pc_step}) > 17'h0FFFF;
    idle_answer_a:
    assert property (!req.valid |=> answer.target == TGT_NONE)
        else $error("answer not idle");
    one_target_a:
    assert property (answer.ext_start == (answer.target == TGT_EXT))
        else $error("bus start without external target");
    code_no_ram_a:
    assert property (c_req |=> answer.target inside {TGT_CODE, TGT_EXT})
        else $error("code fetch sent elsewhere");
    ea_low_ext_a:
    assert property (c_req && !external_access_select
        && !$past(external_access_select)
        && !$past(external_access_select, 2) |=> answer.target == TGT_EXT)
        else $error("code fetch internal with select low");
    ff_wrap_a:
    assert property (adv && pc[23:16] == SEG_CODE
        |=> pc[23:16] == SEG_CODE && pc[15:3] == 13'h0000)
        else $error("FF wrap wrong");
    fe_linear_a:
    assert property (adv && pc[23:16] == SEG_LAST_LIN
        |=> pc[23:16] == SEG_CODE && pc[15:3] == 13'h0000)
        else $error("FE carry wrong");
    seg01_wrap_a:
    assert property (adv && pc[23:16] == SEG_DATA_TOP
        |=> pc[23:16] == SEG_DATA && pc[15:3] == 13'h0000)
        else $error("01 wrap wrong");
    const_quiet_a:
    assert property (c_req && req.is_const |=> !answer.prefetch_hazard)
        else $error("constant read flagged");
    ram_map_a:
    assert property (d00 && req.addr[15:0] < RAM_LIMIT
        |=> answer.target == TGT_RAM && answer.local_addr == $past(req.addr))
        else $error("RAM access misrouted");
    mirror_off_a:
    assert property (d00 && req.addr[15:0] >= MIRROR_FIRST
        && code_mirror_disable |=> answer.target == TGT_EXT)
        else $error("code reached with mirror off");
    mirror_on_a:
    assert property (d00 && req.addr[15:0] >= MIRROR_FIRST
        && !code_mirror_disable
        |=> answer.target inside {TGT_CODE, TGT_EXT}
        && answer.local_addr[15:14] == MIRROR_CODE_HI
        && answer.local_addr[13:0] == $past(req.addr[13:0]))
        else $error("mirror access misrouted");
    sfr_region_a:
    assert property (req.valid && req.space == SPACE_SFR
        |=> answer.target inside {TGT_SFR, TGT_RAM} && !answer.ext_start
        && answer.bit_ok == $past(req.bit_op))
        else $error("SFR access misrouted");
endmodule // address_space_decoder_checker
bind address_space_decoder address_space_decoder_checker u_chk (
    .clk_sys(clk_sys), .arst_n(arst_n),
    .external_access_select(external_access_select),
    .code_mirror_disable(code_mirror_disable), .req(req),
    .pc_load(pc_load), .pc_load_value(pc_load_value),
    .pc_step_en(pc_step_en), .pc_step(pc_step), .answer(answer), .pc(pc));

// File: test/ext_memory_model.sv
/* External memory on the far side: straps the select pin, counts cycles.
   Assumes one ext_start pulse per external bus cycle. */
`timescale 1ns/1ps
module ext_memory_model
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic has_code_rom,
    input wire logic ea_want,
    input wire logic ext_start,
    output logic external_access_select,
    output int cycles_reg
);
    // A board without code memory can only strap the select low.
    assign external_access_select = has_code_rom & ea_want;
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            cycles_reg <= 0;
        else if (ext_start)
            cycles_reg <= cycles_reg + 1;
    end
endmodule // ext_memory_model

// File: test/tb_address_space_decoder.sv
/* Random self-checking bench for the address space decoder.
   Assumes the select pin is only changed while requests are idle. */
`timescale 1ns/1ps
module tb_address_space_decoder
    import addr_map_pkg::*;
;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic has_rom = 1'b1;
    logic ea_want = 1'b0;
    logic md = 1'b0;
    logic ea_pin;
    access_req_t req = '0;
    logic pc_load = 1'b0;
    logic [23:0] pc_load_value = 24'h000000;
    logic pc_step_en = 1'b0;
    logic [2:0] pc_step = 3'h0;
    decode_t answer;
    logic [23:0] pc;
    int ext_seen;
    decode_t exp_ans = '0;
    logic [23:0] pc_m = PC_RESET;
    int n_ext = 0;
    int num_errors = 0;
    int n_checks = 0;
    int seed = 84;
    logic [23:0] bases [16] = '{24'hFF7FFA, 24'hFF8000, 24'hFE0002,
        24'h010000, 24'h000002, 24'h000020, 24'h000100, 24'h000420,
        24'h00C000, 24'h00FFFC, 24'h0000E2, 24'h0000F1, 24'h000083,
        24'h0000BE, 24'h00FF00, 24'h000300};
    logic [23:0] loads [4] = '{24'hFFFFFC, 24'hFEFFFD, 24'h01FFFB,
        24'h00FFFE};
    address_space_decoder u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .external_access_select(ea_pin), .code_mirror_disable(md),
        .req(req), .pc_load(pc_load), .pc_load_value(pc_load_value),
        .pc_step_en(pc_step_en), .pc_step(pc_step), .answer(answer),
        .pc(pc));
    ext_memory_model u_mem (.clk_sys(clk_sys), .arst_n(arst_n),
        .has_code_rom(has_rom), .ea_want(ea_want),
        .ext_start(answer.ext_start), .external_access_select(ea_pin),
        .cycles_reg(ext_seen));
    initial
    begin
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic decode_t model(input access_req_t r);
        decode_t d;
        logic [15:0] o;
        logic [7:0] rf;
        logic d00;
        d = '0;
        o = r.addr[15:0];
        d00 = r.space == SPACE_DATA && r.addr[23:16] == SEG_DATA;
        case (r.addr[7:0])
            SFR_ACC: rf = RF_ACC;
            SFR_B: rf = RF_B;
            SFR_SP: rf = RF_SP;
            SFR_SPH: rf = RF_SPH;
            SFR_DPL: rf = RF_DPL;
            SFR_DPH: rf = RF_DPH;
            SFR_DPXL: rf = RF_DPXL;
            default: rf = 8'h00;
        endcase
        if (!r.valid || !(r.space inside {SPACE_CODE, SPACE_DATA, SPACE_SFR}))
            return d;
        d.target = TGT_EXT;
        d.local_addr = r.addr;
        if (r.space == SPACE_CODE && ea_pin && r.addr[23:16] == SEG_CODE
            && o <= CODE_LAST)
        begin
            d.target = TGT_CODE;
            d.local_addr = {8'h00, o};
            d.prefetch_hazard = !r.is_const && o >= CODE_TOP8_FIRST;
        end
        else if (d00 && o < RAM_LIMIT)
        begin
            d.target = TGT_RAM;
            d.local_addr = {8'h00, o};
            d.bit_ok = r.bit_op && o >= BIT_RAM_FIRST && o <= BIT_RAM_LAST;
        end
        else if (d00 && o >= MIRROR_FIRST && !md)
        begin
            d.target = ea_pin ? TGT_CODE : TGT_EXT;
            d.local_addr = {ea_pin ? 8'h00 : SEG_CODE, 2'b01, o[13:0]};
        end
        else if (r.space == SPACE_SFR)
        begin
            d.target = rf != 8'h00 ? TGT_RAM : TGT_SFR;
            d.local_addr = {16'h0000, rf != 8'h00 ? rf : r.addr[7:0]};
            d.sfr_alias = rf != 8'h00;
            d.bit_ok = r.bit_op;
        end
        d.ext_start = d.target == TGT_EXT;
        return d;
    endfunction
    function automatic logic [23:0] pc_next(input logic [23:0] p,
        input logic [2:0] s);
        logic [16:0] o;
        logic [7:0] g;
        o = {1'b0, p[15:0]} + {14'h0000, s};
        g = p[23:16];
        if (o[16] && (g == SEG_CODE || g == SEG_LAST_LIN))
            g = SEG_CODE;
        else if (o[16])
            g = g == SEG_DATA_TOP ? SEG_DATA : g + 8'h01;
        return {g, o[15:0]};
    endfunction
    task automatic cycle(input access_req_t r, input logic ld,
        input logic se, input logic [2:0] st);
        @(posedge clk_sys);
        #1;
        check({1'b0, answer}, {1'b0, exp_ans});
        check({8'h00, pc}, {8'h00, pc_m});
        n_ext += int'(exp_ans.ext_start);
        req = r;
        pc_load = ld;
        pc_load_value = loads[{$random(seed)} % 4];
        pc_step_en = se;
        pc_step = st;
        exp_ans = model(r);
        pc_m = ld ? pc_load_value : (se ? pc_next(pc_m, st) : pc_m);
    endtask
    initial
    begin
        access_req_t r;
        repeat (2) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        // The last pass models a board with no code memory fitted.
        for (int k = 0; k < 5; k++)
        begin
            has_rom = k != 4;
            ea_want = k[0];
            md = k[1];
            for (int i = 0; i < 250; i++)
            begin
                r = '0;
                r.valid = i > 3 && ($random(seed) & 3) != 0;
                r.space = space_t'(2'({$random(seed)} % 4));
                r.addr = bases[{$random(seed)} % 16]
                    + 24'({$random(seed)} % 4) - 24'h000002;
                r.is_const = 1'($random(seed));
                r.bit_op = 1'($random(seed));
                cycle(r, ($random(seed) & 7) == 0, 1'($random(seed)),
                    3'($random(seed)));
            end
        end
        cycle('0, 1'b0, 1'b0, 3'h0);
        @(posedge clk_sys);
        #1;
        check(32'(ext_seen), 32'(n_ext));
        end_of_test();
    end
    initial
    begin
        #200000;
        num_errors++;
        end_of_test();
    end
endmodule // tb_address_space_decoder
